//--- bench/rsl_master.sv
// Purpose: master controller model on the far side of the rs-485 line
// Assumes: 8 data bits, even parity; idle line held high by bus bias
// Notes:   sole master on the bus, so no contention is modelled
module rsl_master #(
    parameter int DIV = 26
) (
    // clock
    input  wire logic clk,
    // line
    input  wire logic line_tx,
    input  wire logic line_tx_en,
    output logic      line_rx
);
    logic bus;

    // released driver: bias resistors pull the pair to mark
    assign bus = line_tx_en ? line_tx : 1'b1;

    // one bit period, stepped on the falling edge
    task automatic bit_time();
        repeat (DIV) @(negedge clk);
    endtask

    // start, data lsb first, parity, one stop; bad flips parity
    task automatic send(input logic [7:0] b, input logic bad);
        line_rx = 1'b0;
        bit_time();
        for (int k = 0; k < 8; k++)
        begin
            line_rx = b[k];
            bit_time();
        end
        line_rx = ^b ^ bad;
        bit_time();
        line_rx = 1'b1;
        bit_time();
    endtask

    // reply sampled mid-bit; time-out sits in the bench watchdog
    task automatic recv(output logic [7:0] b, output logic stop);
        @(negedge bus);
        repeat (DIV / 2) @(posedge clk);
        for (int k = 0; k < 8; k++)
        begin
            repeat (DIV) @(posedge clk);
            b[k] = bus;
        end
        repeat (2 * DIV) @(posedge clk);
        stop = bus;
    endtask

    // idle mark level
    initial line_rx = 1'b1;
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the rs-485 slave link
// Assumes: clock model rate lowered to 200 kHz to keep counts short
// Notes:   baud code 2 gives a bit period of 41 cycles
module tb import rsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HZ = 200_000;
    localparam int DIV = HZ / 4800;
    localparam int DET = HZ / 10;
    localparam int GAP = GAP_BITS * DIV;
    localparam int WAIT = 5 * HZ / 1000;
    logic clk = 1'b0, rstn = 1'b0, line_rx, line_tx, line_tx_en;
    logic req_valid, req_ready = 1'b0, rsp_valid = 1'b0, rsp_ready;
    logic [7:0] rsp_data = 8'h5a, b;
    logic stop_key = 1'b0, fault_clear = 1'b0, comm_fail, fault_alarm, s;
    logic [4:0] err_count;
    rsl_word_t req_word;
    rsl_action_t action;
    rsl_cfg_t cfg = '{station: 5'h05, baud_code: 3'h2, stop_two: 1'b1,
        parity: PAR_EVEN, width7: 1'b0, detect_time: 8'h00,
        fail_code: 3'h0, tol_count: 5'h01, wait_ms: 7'h05};
    int bad_count = 0, tests_run = 0, cnt;

    rsl_link #(.CLK_HZ(HZ)) dut (.clk(clk), .rstn(rstn), .cfg(cfg),
        .line_rx(line_rx), .line_tx(line_tx), .line_tx_en(line_tx_en),
        .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
        .stop_key(stop_key), .fault_clear(fault_clear),
        .comm_fail(comm_fail), .fault_alarm(fault_alarm),
        .err_count(err_count), .action(action));
    rsl_master #(.DIV(DIV)) mst (.clk(clk), .line_tx(line_tx),
        .line_tx_en(line_tx_en), .line_rx(line_rx));

    // 100 ns period
    always #50 clk = ~clk;

    // compare and count
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // two-byte request, then idle gap that ends it
    task automatic frame(input logic [7:0] st, input logic bad);
        mst.send(st, 1'b0);
        mst.send(8'ha3, bad);
        repeat (GAP + 4) @(negedge clk);
    endtask

    // take one buffered word and compare it
    task automatic pop(input logic [8:0] exp);
        req_ready = 1'b1;
        check(req_word, exp);
        @(negedge clk);
        req_ready = 1'b0;
        @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk);
        check({line_tx, line_tx_en, req_valid, rsp_ready}, 9'h008);
        rstn = 1'b1;
        frame(8'h05, 1'b0);
        pop(9'h105);
        pop(9'h0a3);
        rsp_valid = 1'b1;
        cnt = 0;
        // the reply's start edge must not be missed by the listener
        fork
            mst.recv(b, s);
            begin
                while (rsp_ready !== 1'b1 && cnt < 2 * WAIT)
                begin
                    @(negedge clk);
                    cnt++;
                end
                check(cnt >= WAIT - DIV && cnt <= WAIT + 8, 9'h001);
                @(negedge clk);
                rsp_valid = 1'b0;
            end
        join
        check({s, b}, 9'h15a);
        repeat (DIV / 2 + 4) @(negedge clk);
        check(line_tx_en, 9'h000);
        frame(8'h07, 1'b0);
        check(req_valid, 9'h000);
        frame(8'h05, 1'b1);
        pop(9'h105);
        check({fault_alarm, err_count}, 9'h001);
        frame(8'h05, 1'b1);
        pop(9'h105);
        check({fault_alarm, err_count}, 9'h022);
        // silence watchdog: coast first, then warn and alternate run
        cfg.detect_time = 8'h01;
        cfg.fail_code = 3'h1;
        repeat (DET - 10) @(negedge clk);
        check(comm_fail, 9'h000);
        repeat (20) @(negedge clk);
        check({comm_fail, action}, 9'h028);
        cfg.fail_code = 3'h4;
        fault_clear = 1'b1;
        @(negedge clk);
        fault_clear = 1'b0;
        check({comm_fail, err_count}, 9'h000);
        @(negedge clk);
        check({comm_fail, fault_alarm, action}, 9'h043);
        stop_key = 1'b1;
        @(negedge clk);
        stop_key = 1'b0;
        check(action, 9'h002);
        end_of_test();
    end

    // watchdog, about twice the expected run
    initial
    begin
        #7_000_000;
        bad_count++;
        end_of_test();
    end
endmodule

//--- core/rsl_link.sv
// Behaviour
// R1 - characters framed by start and stop bits, no clock line
// R2 - station setting 1..31; only requests to own station are answered
// R3 - baud codes 0..5 give 1200, 2400, 4800, 9600, 19200, 38400 bps
// R4 - stop setting 0 sends one stop bit, 1 sends two
// R5 - parity code 0 none, 1 even, 2 odd, generated and checked
// R6 - with parity selected exactly one stop bit is used
// R7 - width code 0 gives eight data bits, 1 gives seven
// R8 - failure action code selects decel, coast, emergency, warn, alt run
// R9 - errors are counted; alarm once count exceeds tolerance
// R10 - response start delayed by wait time after request end
// R11 - master receive time-out longer than our wait time
// R12 - one master, at most 31 slaves with distinct stations
// R13 - requests served whatever command source is selected
// R14 - wait time held within 5..65 ms
// R15 - fault tolerance count held within 1..20
// R16 - detection time 0.0..25.5 s in 0.1 s steps
// R17 - failure when no valid own request within detect time; 0 disables
//
// Purpose: rs-485 slave character link with request buffer and fault logic
// Assumes: line inputs synchronous to clk; one master on the bus
// Notes:   request end is a 3.5 character idle gap on the line

// ----------------------------------------------------------------
// request buffer
// ----------------------------------------------------------------
module rsl_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // honest flags from the fill count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------
// link core
// ----------------------------------------------------------------
module rsl_link import rsl_pkg::*; #(
    parameter int unsigned CLK_HZ = CLK_FREQ_HZ
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // settings
    input  wire rsl_cfg_t    cfg,
    // rs-485 line, driver enable high while sending
    input  wire logic        line_rx,
    output logic             line_tx,
    output logic             line_tx_en,
    // received request bytes
    output logic             req_valid,
    input  wire logic        req_ready,
    output rsl_word_t        req_word,
    // response bytes
    input  wire logic        rsp_valid,
    output logic             rsp_ready,
    input  wire logic [7:0]  rsp_data,
    // status and drive control
    input  wire logic        stop_key,
    input  wire logic        fault_clear,
    output logic             comm_fail,
    output logic             fault_alarm,
    output logic [4:0]       err_count,
    output rsl_action_t      action
);
    localparam int unsigned MS_CYC  = CLK_HZ / MS_PER_S;
    localparam int unsigned DET_CYC = MS_CYC * DETECT_STEP_MS;

    // bit period in clocks for a baud code
    function automatic logic [15:0] bit_div(input logic [2:0] code);
        int unsigned b;
        case (code)
            3'h0: b = 1200;
            3'h1: b = 2400;
            3'h2: b = 4800;
            3'h3: b = 9600;
            3'h4: b = 19200;
            3'h5: b = 38400;
            default: b = 9600;  // undefined codes fall back to a safe rate
        endcase
        return 16'(CLK_HZ / b); // R3
    endfunction

    // parity bit to send or expect for a character
    function automatic logic par_of(input logic [7:0] d, input logic odd);
        return (^d) ^ odd; // R5
    endfunction

    function automatic logic [6:0] clamp7(input logic [6:0] v,
                                          input logic [6:0] lo,
                                          input logic [6:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [15:0] div;
    logic        par_en;
    logic [3:0]  nbits;
    logic [6:0]  tol_full;
    logic [4:0]  tol;
    logic        station_ok;
    assign div        = bit_div(cfg.baud_code);
    assign par_en     = (cfg.parity == PAR_EVEN) || (cfg.parity == PAR_ODD);
    assign nbits      = cfg.width7 ? 4'h7 : 4'h8; // R7
    assign tol_full   = clamp7({2'h0, cfg.tol_count}, {2'h0, TOL_MIN},
                               {2'h0, TOL_MAX}); // R15
    assign tol        = tol_full[4:0];
    assign station_ok = (cfg.station >= STATION_MIN) &&
                        (cfg.station <= STATION_MAX); // R2 R12

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    rsl_state_t  rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_par_q;
    logic        rx_done;
    logic        rx_err;
    logic [7:0]  rx_byte;

    assign rx_byte = cfg.width7 ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
    assign rx_done = (rx_st_q == LS_STOP) && (rx_cnt_q == '0);
    assign rx_err  = rx_done && (!line_rx ||
                     (par_en && (rx_par_q !=
                      par_of(rx_byte, cfg.parity == PAR_ODD))));

    // start, data, parity and stop sampled mid-bit
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_st_q  <= LS_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q  <= '0;
            rx_par_q <= 1'b0;
        end
        else if (rx_st_q != LS_IDLE && rx_cnt_q != '0)
            rx_cnt_q <= rx_cnt_q - 1'b1;
        else
        begin
            case (rx_st_q)
                LS_IDLE:
                    if (!line_rx)
                    begin
                        rx_st_q  <= LS_START; // R1
                        rx_cnt_q <= div >> 1;
                    end
                LS_START:
                begin
                    // a short low pulse is noise, not a start bit
                    rx_st_q  <= line_rx ? LS_IDLE : LS_DATA;
                    rx_cnt_q <= div - 1'b1; // R3
                    rx_bit_q <= '0;
                end
                LS_DATA:
                begin
                    rx_sh_q  <= {line_rx, rx_sh_q[7:1]};
                    rx_bit_q <= rx_bit_q + 1'b1;
                    rx_cnt_q <= div - 1'b1;
                    if (rx_bit_q == nbits - 1'b1)
                        rx_st_q <= par_en ? LS_PAR : LS_STOP;
                end
                LS_PAR:
                begin
                    rx_par_q <= line_rx; // R5
                    rx_cnt_q <= div - 1'b1;
                    rx_st_q  <= LS_STOP;
                end
                LS_STOP:
                    rx_st_q <= LS_IDLE;
                default:
                    rx_st_q <= LS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // request framing and address filter
    // ----------------------------------------------------------------
    logic [19:0] gap_q;
    logic        in_frame_q;
    logic        first_q;
    logic        match_q;
    logic        bad_q;
    logic        frame_end;
    logic        push;
    logic        fifo_ready;
    logic        addr_hit;

    assign frame_end = in_frame_q && (gap_q == 20'(div * GAP_BITS));
    assign addr_hit  = first_q && station_ok && (rx_byte[4:0] ==
                       cfg.station) && (rx_byte[7:5] == 3'h0);
    // own requests pass whatever source drives the motor
    assign push      = rx_done && !rx_err && (addr_hit || (!first_q &&
                       match_q)); // R13

    // idle gap closes the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_q      <= '0;
            in_frame_q <= 1'b0;
            first_q    <= 1'b1;
            match_q    <= 1'b0;
            bad_q      <= 1'b0;
        end
        else
        begin
            if (rx_st_q != LS_IDLE || !line_rx)
                gap_q <= '0;
            else if (!frame_end)
                gap_q <= gap_q + 1'b1;
            if (rx_done)
            begin
                in_frame_q <= 1'b1;
                first_q    <= 1'b0;
                if (first_q)
                    match_q <= addr_hit && !rx_err; // R2
                if (rx_err || (push && !fifo_ready))
                    bad_q <= 1'b1;
            end
            else if (frame_end)
            begin
                in_frame_q <= 1'b0;
                first_q    <= 1'b1;
                bad_q      <= 1'b0;
            end
        end
    end

    logic good_req;
    assign good_req = frame_end && match_q && !bad_q;

    rsl_fifo #(
        .WIDTH ($bits(rsl_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_req_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({first_q, rx_byte}),
        .out_valid (req_valid),
        .out_ready (req_ready),
        .out_data  (req_word)
    );

    // ----------------------------------------------------------------
    // error count and alarm
    // ----------------------------------------------------------------
    // overflow of the buffer counts too: the master must repeat
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            err_count <= '0;
        else if (rx_done && (rx_err || (push && !fifo_ready)) &&
                 err_count != '1)
            err_count <= err_count + 1'b1; // R9
        else if (fault_clear)
            err_count <= '0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fault_alarm <= 1'b0;
        else
            fault_alarm <= (err_count > tol); // R9
    end

    // ----------------------------------------------------------------
    // response wait
    // ----------------------------------------------------------------
    logic [23:0] ms_cnt_q;
    logic [6:0]  wait_q;
    logic        waiting_q;
    logic        permit_q;

    // prescaler restarts at request end so the delay is exact
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ms_cnt_q  <= '0;
            wait_q    <= '0;
            waiting_q <= 1'b0;
            permit_q  <= 1'b0;
        end
        else if (good_req)
        begin
            ms_cnt_q  <= 24'(MS_CYC - 1);
            wait_q    <= clamp7(cfg.wait_ms, WAIT_MIN_MS,
                                WAIT_MAX_MS); // R14
            waiting_q <= 1'b1;
            permit_q  <= 1'b0;
        end
        else if (in_frame_q)
            permit_q <= 1'b0; // a new request withdraws the answer
        else if (waiting_q)
        begin
            if (ms_cnt_q != '0)
                ms_cnt_q <= ms_cnt_q - 1'b1;
            else if (wait_q == 7'h01)
            begin
                waiting_q <= 1'b0;
                permit_q  <= 1'b1; // R10
            end
            else
            begin
                wait_q   <= wait_q - 1'b1;
                ms_cnt_q <= 24'(MS_CYC - 1);
            end
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    rsl_state_t  tx_st_q;
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [7:0]  tx_sh_q;
    logic        tx_par_q;
    logic        tx_stop2_q;

    assign rsp_ready = permit_q && (tx_st_q == LS_IDLE) && !in_frame_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_st_q    <= LS_IDLE;
            tx_cnt_q   <= '0;
            tx_bit_q   <= '0;
            tx_sh_q    <= '0;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
            line_tx    <= 1'b1;
            line_tx_en <= 1'b0;
        end
        else if (tx_st_q != LS_IDLE && tx_cnt_q != '0)
            tx_cnt_q <= tx_cnt_q - 1'b1;
        else
        begin
            tx_cnt_q <= div - 1'b1;
            case (tx_st_q)
                LS_IDLE:
                begin
                    line_tx    <= 1'b1;
                    line_tx_en <= 1'b0;
                    if (rsp_valid && rsp_ready)
                    begin
                        tx_st_q    <= LS_START;
                        tx_sh_q    <= cfg.width7 ? {1'b0, rsp_data[6:0]}
                                                 : rsp_data;
                        tx_par_q   <= par_of(cfg.width7 ?
                                      {1'b0, rsp_data[6:0]} : rsp_data,
                                      cfg.parity == PAR_ODD); // R5
                        tx_stop2_q <= cfg.stop_two && !par_en; // R4 R6
                        line_tx    <= 1'b0; // R1
                        line_tx_en <= 1'b1;
                        tx_bit_q   <= '0;
                    end
                end
                LS_START:
                begin
                    tx_st_q  <= LS_DATA;
                    line_tx  <= tx_sh_q[0];
                    tx_sh_q  <= tx_sh_q >> 1;
                    tx_bit_q <= tx_bit_q + 1'b1;
                end
                LS_DATA:
                    if (tx_bit_q == nbits) // R7
                    begin
                        tx_st_q <= par_en ? LS_PAR : LS_STOP;
                        line_tx <= par_en ? tx_par_q : 1'b1;
                    end
                    else
                    begin
                        line_tx  <= tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 1'b1;
                    end
                LS_PAR:
                begin
                    tx_st_q <= LS_STOP;
                    line_tx <= 1'b1;
                end
                LS_STOP:
                    if (tx_stop2_q)
                        tx_stop2_q <= 1'b0; // R4
                    else
                        tx_st_q <= LS_IDLE;
                default:
                    tx_st_q <= LS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // silence watchdog and failure action
    // ----------------------------------------------------------------
    logic [23:0] det_cnt_q;
    logic [7:0]  det_steps_q;

    // counts 0.1 s steps since the last good own request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            det_cnt_q   <= '0;
            det_steps_q <= '0;
        end
        else if (good_req || cfg.detect_time == '0)
        begin
            det_cnt_q   <= '0; // R17
            det_steps_q <= '0;
        end
        else if (det_cnt_q == 24'(DET_CYC - 1))
        begin
            det_cnt_q <= '0;
            if (det_steps_q != '1)
                det_steps_q <= det_steps_q + 1'b1; // R16
        end
        else
            det_cnt_q <= det_cnt_q + 1'b1;
    end

    // action latched at failure; alternate run ends on the stop key
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            comm_fail <= 1'b0;
            action    <= '0;
        end
        else if (!comm_fail && cfg.detect_time != '0 &&
                 det_steps_q >= cfg.detect_time)
        begin
            comm_fail <= 1'b1; // R17
            action    <= '0;
            case (cfg.fail_code) // R8
                3'h0: action.decel_stop <= 1'b1;
                3'h1: action.coast_stop <= 1'b1;
                3'h2: action.emerg_stop <= 1'b1;
                3'h3: action.warn       <= 1'b1;
                3'h4:
                begin
                    action.warn                    <= 1'b1;
                    action.run_second_analog_input <= 1'b1;
                end
                default: action.decel_stop <= 1'b1;
            endcase
        end
        else if (fault_clear)
        begin
            comm_fail <= 1'b0;
            action    <= '0;
        end
        else if (stop_key)
            action.run_second_analog_input <= 1'b0; // R8
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    start_low_a: assert property (@(posedge clk) disable iff (!rstn) // R1
        tx_st_q == LS_START |-> line_tx == 1'b0 && line_tx_en)
        else $error("start bit not low");
    own_station_a: assert property (@(posedge clk) disable iff (!rstn) // R2
        push && first_q |-> rx_byte[4:0] == cfg.station && station_ok)
        else $error("foreign station accepted");
    one_stop_a: assert property (@(posedge clk) disable iff (!rstn) // R6
        tx_st_q == LS_PAR ##1 tx_st_q == LS_STOP |-> !tx_stop2_q)
        else $error("two stops with parity");
    seven_bit_a: assert property (@(posedge clk) disable iff (!rstn) // R7
        push && cfg.width7 |-> rx_byte[7] == 1'b0)
        else $error("eighth bit in seven bit mode");
    alarm_set_a: assert property (@(posedge clk) disable iff (!rstn) // R9
        err_count > tol ##1 err_count > tol |-> fault_alarm)
        else $error("alarm missing");
    wait_gate_a: assert property (@(posedge clk) disable iff (!rstn) // R10
        $rose(line_tx_en) |-> $past(permit_q) && !$past(waiting_q))
        else $error("reply before wait time");
    no_early_a: assert property (@(posedge clk) disable iff (!rstn) // R10
        good_req |=> !permit_q [*5])
        else $error("wait shorter than minimum");
    fail_cause_a: assert property (@(posedge clk) disable iff (!rstn) // R17
        $rose(comm_fail) |-> $past(cfg.detect_time) != 8'h00)
        else $error("failure with watchdog off");
    coast_code_a: assert property (@(posedge clk) disable iff (!rstn) // R8
        $rose(action.coast_stop) |-> $past(cfg.fail_code) == 3'h1)
        else $error("coast with wrong code");
endmodule

//--- include/rsl_pkg.sv
// Purpose: shared types and constants for the rs-485 slave link
// Assumes: 10 MHz system clock, 32-entry buffer of 9-bit request words
// Notes:   all line timing is derived from the clock rate
package rsl_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ   = 10_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned DETECT_STEP_MS = 100;   // 0.1 s per step
    localparam int unsigned GAP_BITS      = 35;     // 3.5 characters

    // ----------------------------------------------------------------
    // setting limits and codes
    // ----------------------------------------------------------------
    localparam logic [4:0] STATION_MIN = 5'h01;
    localparam logic [4:0] STATION_MAX = 5'h1f;
    localparam logic [6:0] WAIT_MIN_MS = 7'h05;
    localparam logic [6:0] WAIT_MAX_MS = 7'h41;
    localparam logic [4:0] TOL_MIN     = 5'h01;
    localparam logic [4:0] TOL_MAX     = 5'h14;
    localparam logic [1:0] PAR_NONE    = 2'h0;
    localparam logic [1:0] PAR_EVEN    = 2'h1;
    localparam logic [1:0] PAR_ODD     = 2'h2;
    localparam int unsigned FIFO_DEPTH = 32;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] station;     // 1..31
        logic [2:0] baud_code;   // 0..5
        logic       stop_two;    // 0: one stop, 1: two stops without parity
        logic [1:0] parity;      // none, even, odd
        logic       width7;      // 0: 8 bits, 1: 7 bits
        logic [7:0] detect_time; // 0.1 s steps, 0 disables
        logic [2:0] fail_code;   // action on link failure
        logic [4:0] tol_count;   // 1..20
        logic [6:0] wait_ms;     // 5..65
    } rsl_cfg_t;

    typedef struct packed {
        logic decel_stop;
        logic coast_stop;
        logic emerg_stop;
        logic warn;
        logic run_second_analog_input;
    } rsl_action_t;

    typedef struct packed {
        logic       first;       // station byte of a request
        logic [7:0] data;
    } rsl_word_t;

    typedef enum logic [2:0] {
        LS_IDLE  = 3'h0,
        LS_START = 3'h1,
        LS_DATA  = 3'h3,
        LS_PAR   = 3'h2,
        LS_STOP  = 3'h6
    } rsl_state_t;

endpackage
